// file: hdl/agd_regbank.sv
/*
 * right agc debounce register, adc flag register and dac power / left
 * headphone common output register, with the right noise debounce filter.
 * assumes a synchronous register port in the clk_in domain, status inputs
 * synchronous to clk_in, and a 100 mhz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module agd_regbank
   import agd_pkg::*;
#(
   parameter int UNIT_CYCLES = AGD_DEB_UNIT_CYCLES
)
(
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire agd_reg_req_t      reg_req_in,
   input  wire agd_chan_status_t  left_status_in,
   input  wire agd_chan_status_t  right_status_in,
   input  wire logic              double_rate_audio_in,
   output logic [7:0]             rd_data_out,
   output agd_dac_ctrl_t          dac_ctrl_out
);

   // =========================================================
   // debounce unit lengths
   // double-rate audio runs the filter twice as fast, so one unit of the
   // encoded time is half as long; the listed times no longer apply
   localparam logic [AGD_PRE_W-1:0] UNIT_FULL = AGD_PRE_W'(UNIT_CYCLES);
   localparam logic [AGD_PRE_W-1:0] UNIT_HALF =
      AGD_PRE_W'((UNIT_CYCLES + 1) / 2);

   agd_bank_state_t        st_ff;
   agd_bank_state_t        nxt_st;
   logic [AGD_PRE_W-1:0]   unit_cycles;
   logic [4:0]             noise_code;
   logic [2:0]             sig_code;
   logic [AGD_UNITS_W-1:0] noise_units;
   logic [AGD_UNITS_W-1:0] sig_units;
   logic                   right_noise_deb;
   logic                   left_pga_eq;
   logic                   right_pga_eq;
   logic                   left_sat;
   logic                   right_sat;
   logic [1:0]             wr_mode;

   // =========================================================
   // code to units of 0.5 ms
   function automatic logic [AGD_UNITS_W-1:0] short_units(
      input logic [2:0] code
   );
      logic [AGD_UNITS_W-1:0] u;
      u = '0;
      if (code != 3'h0) begin
         u = AGD_UNITS_W'(1) << (code - 3'h1);
      end
      return u;
   endfunction : short_units

   function automatic logic [AGD_UNITS_W-1:0] noise_to_units(
      input logic [4:0] code
   );
      logic [AGD_UNITS_W-1:0] mult;
      logic [AGD_UNITS_W-1:0] u;
      mult = AGD_UNITS_W'(code - AGD_LONG_BASE_CODE);
      if (code > AGD_LONG_BASE_CODE) begin
         u = AGD_UNITS_W'(mult * AGD_LONG_STEP_UNITS);
      end else begin
         u = short_units(code[2:0]);
      end
      return u;
   endfunction : noise_to_units

   // decode the debounce fields into unit counts
   always_comb begin
      noise_code  = st_ff.debounce[AGD_NOISE_DEB_LSB +: AGD_NOISE_DEB_W];
      sig_code    = st_ff.debounce[AGD_SIG_DEB_LSB +: AGD_SIG_DEB_W];
      noise_units = noise_to_units(noise_code);
      sig_units   = short_units(sig_code);
      unit_cycles = double_rate_audio_in ? UNIT_HALF : UNIT_FULL;
   end

   // =========================================================
   // right channel noise detection filter
   agd_debounce u_right_deb (
      .clk_in          (clk_in),
      .rst_n_in        (rst_n_in),
      .raw_in          (right_status_in.below_noise),
      .unit_cycles_in  (unit_cycles),
      .noise_units_in  (noise_units),
      .signal_units_in (sig_units),
      .filtered_out    (right_noise_deb)
   );

   // =========================================================
   // live status comparisons
   always_comb begin
      left_pga_eq  = (left_status_in.gain_applied ==
                      left_status_in.gain_prog);
      right_pga_eq = (right_status_in.gain_applied ==
                      right_status_in.gain_prog);
      left_sat     = (left_status_in.agc_gain ==
                      left_status_in.agc_max_gain);
      right_sat    = (right_status_in.agc_gain ==
                      right_status_in.agc_max_gain);
      wr_mode      = reg_req_in.wdata[AGD_HPCOM_LSB +: 2];
   end

   // =========================================================
   // next state: flags, writes and read data
   always_comb begin
      nxt_st = st_ff;

      // flags are resampled every cycle, never latched
      nxt_st.flags[AGD_FLG_L_PGA]   = left_pga_eq;
      nxt_st.flags[AGD_FLG_R_PGA]   = right_pga_eq;
      nxt_st.flags[AGD_FLG_L_PWR]   = left_status_in.adc_powered;
      nxt_st.flags[AGD_FLG_R_PWR]   = right_status_in.adc_powered;
      nxt_st.flags[AGD_FLG_L_NOISE] = left_status_in.below_noise;
      nxt_st.flags[AGD_FLG_R_NOISE] = right_noise_deb;
      nxt_st.flags[AGD_FLG_L_SAT]   = left_sat;
      nxt_st.flags[AGD_FLG_R_SAT]   = right_sat;

      // register writes; the flag offset has no write path at all
      if (reg_req_in.wr_en) begin
         if (reg_req_in.addr == AGD_OFS_DEBOUNCE) begin
            nxt_st.debounce = reg_req_in.wdata;
         end else if (reg_req_in.addr == AGD_OFS_DAC_PWR) begin
            nxt_st.dac.left_dac_power  =
               reg_req_in.wdata[AGD_DAC_L_PWR];
            nxt_st.dac.right_dac_power =
               reg_req_in.wdata[AGD_DAC_R_PWR];
            // the reserved mode is dropped so the driver never sees it
            if (wr_mode != AGD_HPCOM_RSVD) begin
               nxt_st.dac.hpcom_mode = wr_mode;
            end
         end else if (reg_req_in.addr == AGD_OFS_FLAGS) begin
            nxt_st.flags = nxt_st.flags;
         end
      end

      // read data holds until the next read
      if (reg_req_in.rd_en) begin
         if (reg_req_in.addr == AGD_OFS_DEBOUNCE) begin
            nxt_st.rd_data = st_ff.debounce;
         end else if (reg_req_in.addr == AGD_OFS_FLAGS) begin
            nxt_st.rd_data = st_ff.flags;
         end else if (reg_req_in.addr == AGD_OFS_DAC_PWR) begin
            // low four bits are not stored and read as zero
            nxt_st.rd_data = {st_ff.dac.left_dac_power,
                              st_ff.dac.right_dac_power,
                              st_ff.dac.hpcom_mode,
                              4'h0};
         end else begin
            nxt_st.rd_data = AGD_RD_UNMAPPED;
         end
      end
   end

   // state register
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_ff.debounce <= AGD_RST_DEBOUNCE;
         st_ff.flags    <= AGD_RST_FLAGS;
         st_ff.dac      <= agd_dac_ctrl_t'(AGD_RST_DAC_PWR[7:4]);
         st_ff.rd_data  <= AGD_RD_UNMAPPED;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs come straight from the state register
   assign rd_data_out  = st_ff.rd_data;
   assign dac_ctrl_out = st_ff.dac;

   // =========================================================
   // checks
   default clocking bank_cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence flag_read_s;
      reg_req_in.rd_en && (reg_req_in.addr == AGD_OFS_FLAGS);
   endsequence

   sequence dac_write_s;
      reg_req_in.wr_en && (reg_req_in.addr == AGD_OFS_DAC_PWR);
   endsequence

   noise_long_map_a: assert property (
      (noise_code > 5'h07) |->
         (noise_units == AGD_UNITS_W'(12'h080 * (noise_code - 5'h07))))
      else $error("long noise debounce mapped wrong");

   noise_short_map_a: assert property (
      (noise_code == 5'h07) |-> (noise_units == 12'h040))
      else $error("32 ms noise debounce mapped wrong");

   signal_map_a: assert property (
      (sig_code == 3'h1) |-> (sig_units == 12'h001))
      else $error("0.5 ms signal debounce mapped wrong");

   dra_unit_a: assert property (
      double_rate_audio_in |-> (unit_cycles < UNIT_FULL || UNIT_FULL < 2))
      else $error("double rate did not shorten the unit");

   left_pga_read_a: assert property (
      flag_read_s |=>
         (rd_data_out[AGD_FLG_L_PGA] == $past(left_pga_eq, 2)) &&
         (rd_data_out[AGD_FLG_L_PWR] ==
          $past(left_status_in.adc_powered, 2)))
      else $error("left pga or power flag read wrong");

   right_pga_read_a: assert property (
      flag_read_s |=>
         (rd_data_out[AGD_FLG_R_PGA] == $past(right_pga_eq, 2)) &&
         (rd_data_out[AGD_FLG_R_PWR] ==
          $past(right_status_in.adc_powered, 2)))
      else $error("right pga or power flag read wrong");

   noise_flags_a: assert property (
      flag_read_s |=>
         (rd_data_out[AGD_FLG_L_NOISE] ==
          $past(left_status_in.below_noise, 2)) &&
         (rd_data_out[AGD_FLG_R_NOISE] == $past(right_noise_deb, 2)))
      else $error("noise detection flag read wrong");

   sat_flags_a: assert property (
      flag_read_s |=>
         (rd_data_out[AGD_FLG_L_SAT] == $past(left_sat, 2)) &&
         (rd_data_out[AGD_FLG_R_SAT] == $past(right_sat, 2)))
      else $error("saturation flag read wrong");

   dac_power_a: assert property (
      dac_write_s |=>
         (dac_ctrl_out.left_dac_power ==
          $past(reg_req_in.wdata[AGD_DAC_L_PWR])) &&
         (dac_ctrl_out.right_dac_power ==
          $past(reg_req_in.wdata[AGD_DAC_R_PWR])))
      else $error("dac power bits not taken from write");

   hpcom_mode_a: assert property (
      dac_write_s |=>
         (dac_ctrl_out.hpcom_mode != AGD_HPCOM_RSVD) &&
         ($past(wr_mode) == AGD_HPCOM_RSVD ||
          dac_ctrl_out.hpcom_mode == $past(wr_mode)))
      else $error("headphone common mode write handled wrong");

   flag_write_a: assert property (
      reg_req_in.wr_en && (reg_req_in.addr == AGD_OFS_FLAGS) |=>
         $stable(st_ff.debounce) && $stable(st_ff.dac))
      else $error("write to flag register changed state");

   rsvd_zero_a: assert property (
      reg_req_in.rd_en && (reg_req_in.addr == AGD_OFS_DAC_PWR) |=>
         (rd_data_out[3:0] == 4'h0))
      else $error("reserved bits did not read zero");

   // =========================================================
   // storage, read-back and code map end points
   sequence deb_read_s;
      reg_req_in.rd_en && (reg_req_in.addr == AGD_OFS_DEBOUNCE);
   endsequence

   sequence dac_read_s;
      reg_req_in.rd_en && (reg_req_in.addr == AGD_OFS_DAC_PWR);
   endsequence

   debounce_write_a: assert property (
      reg_req_in.wr_en && (reg_req_in.addr == AGD_OFS_DEBOUNCE) |=>
         (st_ff.debounce == $past(reg_req_in.wdata)))
      else $error("debounce register write not stored");

   debounce_read_a: assert property (
      deb_read_s |=> (rd_data_out == $past(st_ff.debounce)))
      else $error("debounce register read back wrong");

   dac_read_a: assert property (
      dac_read_s |=> (rd_data_out[7:4] == $past(st_ff.dac)))
      else $error("dac power register read back wrong");

   // anything but a write at the dac offset leaves the controls alone
   dac_hold_a: assert property (
      !(reg_req_in.wr_en && (reg_req_in.addr == AGD_OFS_DAC_PWR)) |=>
         $stable(dac_ctrl_out))
      else $error("dac controls changed without a write");

   // flags follow the live inputs one cycle later, with no history; the right noise flag follows its debounce filter
   flags_live_a: assert property (
      1'b1 |=> (st_ff.flags[AGD_FLG_L_PWR] ==
                $past(left_status_in.adc_powered)))
      else $error("flag register did not follow live state");

   noise_zero_map_a: assert property (
      (noise_code == 5'h00) |-> (noise_units == 12'h000))
      else $error("0 ms noise debounce mapped wrong");

   noise_mid_map_a: assert property (
      (noise_code == 5'h04) |-> (noise_units == 12'h008))
      else $error("4 ms noise debounce mapped wrong");

   noise_first_long_a: assert property (
      (noise_code == 5'h08) |-> (noise_units == 12'h080))
      else $error("64 ms noise debounce mapped wrong");

   noise_second_long_a: assert property (
      (noise_code == 5'h09) |-> (noise_units == 12'h100))
      else $error("128 ms noise debounce mapped wrong");

   noise_top_map_a: assert property (
      (noise_code == 5'h1f) |-> (noise_units == 12'hc00))
      else $error("1536 ms noise debounce mapped wrong");

   signal_zero_map_a: assert property (
      (sig_code == 3'h0) |-> (sig_units == 12'h000))
      else $error("0 ms signal debounce mapped wrong");

   signal_mid_map_a: assert property (
      (sig_code == 3'h4) |-> (sig_units == 12'h008))
      else $error("4 ms signal debounce mapped wrong");

   signal_top_map_a: assert property (
      (sig_code == 3'h7) |-> (sig_units == 12'h040))
      else $error("32 ms signal debounce mapped wrong");

   dra_off_unit_a: assert property (
      !double_rate_audio_in |-> (unit_cycles == UNIT_FULL))
      else $error("unit length changed with double rate off");

endmodule : agd_regbank
`default_nettype wire

// file: hdl/agd_pkg.sv
/*
 * shared constants and types for the agc debounce, adc flag and dac power
 * register bank: register offsets, field positions, reset values, timing
 * and the packed carriers used at the module ports.
 * assumes a single 100 mhz clock domain and an 8-bit register access port.
 */
package agd_pkg;

   // =========================================================
   // register offsets and reset values
   localparam logic [7:0] AGD_OFS_DEBOUNCE = 8'h23;
   localparam logic [7:0] AGD_OFS_FLAGS    = 8'h24;
   localparam logic [7:0] AGD_OFS_DAC_PWR  = 8'h25;
   localparam logic [7:0] AGD_RST_DEBOUNCE = 8'h00;
   localparam logic [7:0] AGD_RST_FLAGS    = 8'h00;
   localparam logic [7:0] AGD_RST_DAC_PWR  = 8'h00;
   localparam logic [7:0] AGD_RD_UNMAPPED  = 8'h00;

   // =========================================================
   // field positions
   localparam int AGD_NOISE_DEB_LSB = 3;
   localparam int AGD_NOISE_DEB_W   = 5;
   localparam int AGD_SIG_DEB_LSB   = 0;
   localparam int AGD_SIG_DEB_W     = 3;
   localparam int AGD_FLG_L_PGA     = 7;
   localparam int AGD_FLG_L_PWR     = 6;
   localparam int AGD_FLG_L_NOISE   = 5;
   localparam int AGD_FLG_L_SAT     = 4;
   localparam int AGD_FLG_R_PGA     = 3;
   localparam int AGD_FLG_R_PWR     = 2;
   localparam int AGD_FLG_R_NOISE   = 1;
   localparam int AGD_FLG_R_SAT     = 0;
   localparam int AGD_DAC_L_PWR     = 7;
   localparam int AGD_DAC_R_PWR     = 6;
   localparam int AGD_HPCOM_LSB     = 4;

   // left headphone common output modes
   localparam logic [1:0] AGD_HPCOM_DIFF   = 2'h0;
   localparam logic [1:0] AGD_HPCOM_CONST  = 2'h1;
   localparam logic [1:0] AGD_HPCOM_SINGLE = 2'h2;
   localparam logic [1:0] AGD_HPCOM_RSVD   = 2'h3;

   // =========================================================
   // timing: debounce counts in units of 0.5 ms
   localparam int AGD_CLK_PERIOD_NS   = 10;
   localparam int AGD_DEB_UNIT_NS     = 500000;
   localparam int AGD_DEB_UNIT_CYCLES = AGD_DEB_UNIT_NS / AGD_CLK_PERIOD_NS;
   localparam int AGD_PRE_W           = 20;
   localparam int AGD_UNITS_W         = 12;
   localparam logic [AGD_UNITS_W-1:0] AGD_LONG_STEP_UNITS = 12'h080;
   localparam logic [4:0] AGD_LONG_BASE_CODE = 5'h07;

   // =========================================================
   // types
   typedef enum logic [1:0] {
      AGD_DEB_SIGNAL = 2'b01,
      AGD_DEB_NOISE  = 2'b10
   } agd_deb_state_t;

   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } agd_reg_req_t;

   typedef struct packed {
      logic [7:0] gain_applied;
      logic [7:0] gain_prog;
      logic       adc_powered;
      logic [7:0] agc_gain;
      logic [7:0] agc_max_gain;
      logic       below_noise;
   } agd_chan_status_t;

   typedef struct packed {
      logic       left_dac_power;
      logic       right_dac_power;
      logic [1:0] hpcom_mode;
   } agd_dac_ctrl_t;

   typedef struct packed {
      logic [7:0]    debounce;
      logic [7:0]    flags;
      agd_dac_ctrl_t dac;
      logic [7:0]    rd_data;
   } agd_bank_state_t;

   typedef struct packed {
      agd_deb_state_t         state;
      logic [AGD_PRE_W-1:0]   pre;
      logic [AGD_UNITS_W-1:0] units;
   } agd_deb_reg_t;

endpackage : agd_pkg

// file: hdl/agd_debounce.sv
/*
 * debounce filter for one agc signal-detection level.
 * assumes raw_in is synchronous to clk_in and that the unit length and
 * both targets are held stable by the register bank.
 */
`timescale 1ns/1ps
`default_nettype none
module agd_debounce
   import agd_pkg::*;
(
   input  wire logic                   clk_in,
   input  wire logic                   rst_n_in,
   input  wire logic                   raw_in,
   input  wire logic [AGD_PRE_W-1:0]   unit_cycles_in,
   input  wire logic [AGD_UNITS_W-1:0] noise_units_in,
   input  wire logic [AGD_UNITS_W-1:0] signal_units_in,
   output logic                        filtered_out
);

   // =========================================================
   // state
   agd_deb_reg_t           st_ff;
   agd_deb_reg_t           nxt_st;
   logic [AGD_UNITS_W-1:0] target;
   logic                   pending;

   // a change must hold for the whole target before the level flips
   always_comb begin
      nxt_st  = st_ff;
      target  = (st_ff.state == AGD_DEB_SIGNAL) ? noise_units_in
                                                : signal_units_in;
      pending = raw_in ^ (st_ff.state == AGD_DEB_NOISE);
      if (!pending) begin
         // a bounce restarts the wait from zero
         nxt_st.pre   = '0;
         nxt_st.units = '0;
      end else if (st_ff.units >= target) begin
         case (st_ff.state)
            AGD_DEB_SIGNAL: nxt_st.state = AGD_DEB_NOISE;
            AGD_DEB_NOISE:  nxt_st.state = AGD_DEB_SIGNAL;
            default:        nxt_st.state = AGD_DEB_SIGNAL;
         endcase
         nxt_st.pre   = '0;
         nxt_st.units = '0;
      end else if (st_ff.pre >= unit_cycles_in - AGD_PRE_W'(1)) begin
         nxt_st.pre   = '0;
         nxt_st.units = st_ff.units + AGD_UNITS_W'(1);
      end else begin
         nxt_st.pre = st_ff.pre + AGD_PRE_W'(1);
      end
   end

   // state register
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_ff <= '{state: AGD_DEB_SIGNAL, pre: '0, units: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign filtered_out = (st_ff.state == AGD_DEB_NOISE);

   // =========================================================
   // checks
   default clocking deb_cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   zero_target_a: assert property (
      pending && (target == '0) |=> (filtered_out == $past(raw_in)))
      else $error("zero debounce did not flip at once");

   bounce_holds_a: assert property (
      !pending |=> (filtered_out == $past(filtered_out)))
      else $error("level changed without a pending change");

endmodule : agd_debounce
`default_nettype wire

// file: test/agd_regbank_test.sv
/*
 * self-checking bench for the agc debounce, adc flag and dac power bank.
 * assumes agd_pkg and agd_regbank are compiled first; one 100 mhz clock,
 * synchronous active-low reset, read data one cycle after the read edge.
 */
`timescale 1ns/1ps
`default_nettype none
module agc_debounce_adc_flags_dac_power_test
   import agd_pkg::*;
();
   // short unit keeps the 1536 ms code inside about 12k cycles
   localparam int UNIT = 4;

   logic             clk_in;
   logic             rst_n_in;
   logic             double_rate;
   agd_reg_req_t     req;
   agd_chan_status_t left_st;
   agd_chan_status_t right_st;
   logic [7:0]       rd_data;
   agd_dac_ctrl_t    dac;
   logic [7:0]       exp_q[$];
   logic             rd_seen;
   logic [7:0]       deb_reg;
   logic [7:0]       v;
   logic [3:0]       dac_reg;
   int               err_total;
   int               num_checks;
   int               seed;
   int               unit_now;
   int               c;

   agd_regbank #(.UNIT_CYCLES(UNIT)) i_agd_regbank (
      .clk_in               (clk_in),
      .rst_n_in             (rst_n_in),
      .reg_req_in           (req),
      .left_status_in       (left_st),
      .right_status_in      (right_st),
      .double_rate_audio_in (double_rate),
      .rd_data_out          (rd_data),
      .dac_ctrl_out         (dac)
   );

   // =========================================================
   // clock, watchdog and result watcher
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // whole run needs about 16k cycles, so 40k means a hang
   initial begin
      #400000;
      err_total++;
      end_of_test();
   end

   always @(posedge clk_in) rd_seen <= req.rd_en & rst_n_in;

   // an empty queue expects x, so a stray read always mismatches
   always @(negedge clk_in) begin
      if (rd_seen) begin
         check(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
      end
   end

   // =========================================================
   // tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test();
      if (err_total == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic op(input logic w, input logic r, input logic [7:0] a,
                     input logic [7:0] d);
      @(negedge clk_in);
      req = '{wr_en: w, rd_en: r, addr: a, wdata: d};
   endtask : op

   task automatic idle();
      op(1'b0, 1'b0, 8'h00, 8'h00);
   endtask : idle

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      op(1'b0, 1'b1, a, 8'h00);
   endtask : rd

   // write plus the bench's own copy of the writable registers
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      op(1'b1, 1'b0, a, d);
      if (a == 8'h23) deb_reg = d;
      if (a == 8'h25) begin
         dac_reg[3:2] = d[7:6];
         if (d[5:4] != 2'h3) dac_reg[1:0] = d[5:4];
      end
   endtask : wr

   function automatic int units(input int code);
      return (code == 0) ? 0 : (code <= 7) ? (1 << (code - 1))
                                           : 128 * (code - 7);
   endfunction : units

   function automatic logic [7:0] flags_of(input agd_chan_status_t l,
                                           input agd_chan_status_t r);
      return {l.gain_applied == l.gain_prog, l.adc_powered, l.below_noise,
              l.agc_gain == l.agc_max_gain, r.gain_applied == r.gain_prog,
              r.adc_powered, r.below_noise, r.agc_gain == r.agc_max_gain};
   endfunction : flags_of

   // random status with matches forced half of the time
   function automatic agd_chan_status_t rnd_chan();
      agd_chan_status_t s;
      logic [63:0]      r;
      r = {$random(seed), $random(seed)};
      s = r[33:0];
      if (r[40]) s.gain_prog = s.gain_applied;
      if (r[41]) s.agc_max_gain = s.agc_gain;
      return s;
   endfunction : rnd_chan

   // raw right level change, flag probed just before and after n units
   task automatic deb_step(input logic lvl, input int n);
      @(negedge clk_in);
      right_st.below_noise = lvl;
      if (n * unit_now > 3) begin
         repeat (n * unit_now - 3) @(negedge clk_in);
         rd(8'h24, {6'h00, ~lvl, 1'b0});
         idle();
      end
      repeat (8) @(negedge clk_in);
      rd(8'h24, {6'h00, lvl, 1'b0});
      idle();
   endtask : deb_step

   // =========================================================
   // main sequence
   initial begin
      seed = 32'hfa93;
      err_total = 0;
      num_checks = 0;
      unit_now = UNIT;
      double_rate = 1'b0;
      deb_reg = 8'h00;
      dac_reg = 4'h0;
      rst_n_in = 1'b0;
      req = '0;
      // base status: no gain match, no saturation, so flags read 00
      left_st = '{gain_applied: 8'h01, agc_gain: 8'h01, default: '0};
      right_st = left_st;
      repeat (16) @(negedge clk_in);
      rst_n_in = 1'b1;
      // reset values, unmapped place and read-only flags
      rd(8'h23, 8'h00);
      rd(8'h24, 8'h00);
      rd(8'h25, 8'h00);
      wr(8'h26, 8'h5a);
      wr(8'h24, 8'hff);
      rd(8'h26, 8'h00);
      rd(8'h24, 8'h00);
      idle();
      // live flags against random status, with writes in between
      for (int i = 0; i < 24; i++) begin
         @(negedge clk_in);
         left_st = rnd_chan();
         right_st = rnd_chan();
         repeat (3) @(negedge clk_in);
         rd(8'h24, flags_of(left_st, right_st));
         wr(8'h24, ~flags_of(left_st, right_st));
         rd(8'h24, flags_of(left_st, right_st));
         idle();
      end
      @(negedge clk_in);
      left_st = '{gain_applied: 8'h01, agc_gain: 8'h01, default: '0};
      right_st = left_st;
      // dac power and common output mode, every legal mode code in turn
      for (int i = 0; i < 12; i++) begin
         v = 8'($random(seed));
         v[5:4] = 2'(i % 3);
         v[3:0] = 4'h0;
         wr(8'h25, v);
         rd(8'h25, {dac_reg, 4'h0});
         idle();
         @(negedge clk_in);
         check({4'h0, dac}, {4'h0, dac_reg});
      end
      // every signal code, noise codes 0..9 and the top code
      for (int i = 0; i < 11; i++) begin
         c = (i < 10) ? i : 31;
         v = {c[4:0], 3'(i % 8)};
         exp_q.push_back(deb_reg);
         op(1'b1, 1'b1, 8'h23, v);
         deb_reg = v;
         rd(8'h23, v);
         idle();
         deb_step(1'b1, units(c));
         deb_step(1'b0, units(i % 8));
      end
      // one-cycle dip restarts the 8 unit noise count
      wr(8'h23, 8'h20);
      idle();
      @(negedge clk_in);
      right_st.below_noise = 1'b1;
      repeat (20) @(negedge clk_in);
      right_st.below_noise = 1'b0;
      @(negedge clk_in);
      right_st.below_noise = 1'b1;
      repeat (24) @(negedge clk_in);
      rd(8'h24, 8'h00);
      idle();
      repeat (12) @(negedge clk_in);
      rd(8'h24, 8'h02);
      idle();
      deb_step(1'b0, 0);
      // double-rate audio halves the unit, 16 units both ways
      double_rate = 1'b1;
      unit_now = (UNIT + 1) / 2;
      wr(8'h23, 8'h2d);
      idle();
      deb_step(1'b1, 16);
      deb_step(1'b0, 16);
      repeat (4) @(negedge clk_in);
      end_of_test();
   end
endmodule : agc_debounce_adc_flags_dac_power_test
`default_nettype wire
